/* File: core_model.sv */
`timescale 1ns/1ps
module core_model import irq_vec_pkg::*; (
	input  wire logic            aclk,
	input  wire logic            pc_load,
	input  wire logic [PC_W-1:0] pc_out,
	input  wire logic            jump,
	input  wire logic [PC_W-1:0] jump_pc,
	output logic      [PC_W-1:0] pc_in,
	output int                   loads
);
	initial pc_in = '0;
	initial loads = 0;
	// follow every load
	// a load from the block beats a bench branch, as in a real core
	always @(posedge aclk) begin
		if (pc_load) begin
			pc_in <= pc_out;
			loads <= loads + 1;
		end else if (jump)
			pc_in <= jump_pc;
	end
endmodule // core_model

/* File: irq_and_reset_vectoring.sv */
`timescale 1ns/1ps
module irq_and_reset_vectoring import irq_vec_pkg::*; (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               por_n,
	input  wire logic               master_clear_pin_n,
	input  wire logic               brownout_enable_cfg,
	input  wire logic               ext_irq_pin,
	input  wire logic               port_change_evt,
	input  wire logic               timer0_ovf_evt,
	input  wire logic [PF1_W-1:0]   periph_evt1,
	input  wire logic [PF2_W-1:0]   periph_evt2,
	input  wire logic [PC_W-1:0]    pc_in,
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic                    pc_load,
	output logic [PC_W-1:0]         pc_out,
	output logic                    sleeping,
	output logic                    irq
);
	// pin synchronisers
	logic [1:0] ext_s, master_clear_pin_s, por_s;
	logic       ext_d;
	always_ff @(posedge aclk) begin
		ext_s  <= {ext_s[0], ext_irq_pin};
		master_clear_pin_s <= {master_clear_pin_s[0], master_clear_pin_n};
		por_s  <= {por_s[0], por_n};
		ext_d  <= ext_s[1];
	end
	wire ext_rise = ext_s[1] & ~ext_d;
	wire master_clear_pin_low = ~master_clear_pin_s[1];
	wire por_low  = ~por_s[1] | ~aresetn;

	logic [7:0]         ctrl;
	logic [PF1_W-1:0]   pflag1, pen1;
	logic [PF2_W-1:0]   pflag2, pen2;
	logic [7:0]         status;
	logic [1:0]         pwr;
	logic [PC_W-1:0]    stack [STK_D];
	logic [2:0]         sp;
	logic [1:0]         lat_cnt;
	logic               rst_q;
	logic [EVT_W-1:0]   evt_stat, evt_en;
	core_st_t           st;

	// bus decode
	logic       aw_got, w_got, ar_pend;
	logic [7:0] aw_ofs;
	logic [31:0] wd;
	wire        do_wr = aw_got & w_got & ~s_axi_bvalid;
	wire        wr_ctrl = do_wr & (aw_ofs == OFS_CTRL);
	wire        wr_pf1  = do_wr & (aw_ofs == OFS_PFLAG1);
	wire        wr_pf2  = do_wr & (aw_ofs == OFS_PFLAG2);
	wire        wr_pe1  = do_wr & (aw_ofs == OFS_PEN1);
	wire        wr_pe2  = do_wr & (aw_ofs == OFS_PEN2);
	wire        wr_stat = do_wr & (aw_ofs == OFS_STATUS);
	wire        wr_pwr  = do_wr & (aw_ofs == OFS_PWR);
	wire        wr_cmd  = do_wr & (aw_ofs == OFS_CMD);
	wire        wr_een  = do_wr & (aw_ofs == OFS_EVT_EN);
	wire        wr_eclr = do_wr & (aw_ofs == OFS_EVT_CLR);
	wire        wr_map  = wr_ctrl | wr_pf1 | wr_pf2 | wr_pe1 | wr_pe2 | wr_stat | wr_pwr | wr_cmd
	                    | wr_een | wr_eclr;

	wire cmd_return = wr_cmd & wd[C_RETURN];
	wire cmd_sleep  = wr_cmd & wd[C_SLEEP];
	wire cmd_bor    = wr_cmd & wd[C_BOR];
	wire cmd_wdt    = wr_cmd & wd[C_WDT];

	wire [PF1_W-1:0] pev1 = periph_evt1;
	wire [PF2_W-1:0] pev2 = periph_evt2;
	wire [PF1_W-1:0] pact1 = pflag1 & pen1;
	wire [PF2_W-1:0] pact2 = pflag2 & pen2;
	wire per_act = (|pact1 | |pact2) & ctrl[B_PER_E];
	wire src_act = (ctrl[B_EXT_F] & ctrl[B_EXT_E]) | (ctrl[B_CHG_F] & ctrl[B_CHG_E])
	             | (ctrl[B_TMR_F] & ctrl[B_TMR_E]) | per_act;
	wire take_irq  = src_act & ctrl[B_GIE] & (st == ST_RUN);
	wire lat_done  = (lat_cnt == 2'(LAT_CYC - 1));
	wire do_vec    = take_irq & lat_done;
	// wake with enable vectors, else pc+1
	wire do_wake   = (st == ST_SLEEP) & src_act;
	wire wake_vec  = do_wake & ctrl[B_GIE];
	wire master_clear_pin_sleep = master_clear_pin_low & (st == ST_SLEEP);
	wire any_reset = por_low | master_clear_pin_low | cmd_bor | cmd_wdt;

	wire [7:0] ctrl_w = wr_ctrl ? wd[7:0] : ctrl;
	logic [7:0] next_ctrl;
	always_comb begin
		next_ctrl = ctrl_w;
		next_ctrl[B_EXT_F] = ctrl_w[B_EXT_F] | ext_rise;
		next_ctrl[B_CHG_F] = ctrl_w[B_CHG_F] | port_change_evt;
		next_ctrl[B_TMR_F] = ctrl_w[B_TMR_F] | timer0_ovf_evt;
		if (do_vec | wake_vec)
			next_ctrl[B_GIE] = 1'b0;
		else if (cmd_return)
			next_ctrl[B_GIE] = 1'b1;
	end

	always_ff @(posedge aclk) begin
		// reset clears enable; wake keeps flags
		if (por_low) begin
			ctrl   <= 8'h00;
			pflag1 <= '0;
			pflag2 <= '0;
			pen1   <= '0;
			pen2   <= '0;
		end else if (master_clear_pin_low | cmd_bor | cmd_wdt) begin
			ctrl   <= {1'b0, 6'h00, ctrl[B_CHG_F]};
			pflag1 <= '0;
			pflag2 <= '0;
			pen1   <= '0;
			pen2   <= '0;
		end else begin
			ctrl   <= next_ctrl;
			pflag1 <= (wr_pf1 ? wd[PF1_W-1:0] : pflag1) | pev1;
			pflag2 <= (wr_pf2 ? wd[PF2_W-1:0] : pflag2) | pev2;
			if (wr_pe1)
				pen1 <= wd[PF1_W-1:0];
			if (wr_pe2)
				pen2 <= wd[PF2_W-1:0];
		end
	end

	// status and power control
	always_ff @(posedge aclk) begin
		if (por_low) begin
			status   <= STATUS_POR;
			pwr[B_POR] <= 1'b0;
			pwr[B_BOR] <= brownout_enable_cfg;
		end else if (master_clear_pin_sleep) begin
			status <= {3'b000, 1'b1, 1'b0, status[2:0]};
		end else if (master_clear_pin_low) begin
			status <= status & STATUS_TOP_MASK;
		end else if (cmd_wdt) begin
			status <= {3'b000, 1'b0, 1'b1, status[2:0]};
		end else if (cmd_bor) begin
			status <= {3'b000, 1'b1, 1'b1, status[2:0]};
			pwr[B_BOR] <= 1'b0;
		end else if (do_wake) begin
			status[B_TO] <= 1'b1;
			status[B_PD] <= 1'b0;
		end else if (cmd_sleep) begin
			status[B_TO] <= 1'b1;
			status[B_PD] <= 1'b0;
		end else begin
			if (wr_stat)
				status <= wd[7:0];
			if (wr_pwr)
				pwr <= wd[1:0];
		end
	end

	// core state, latency and program counter
	always_ff @(posedge aclk) begin
		// one load as a reset ends, however long the reset was held
		rst_q   <= any_reset;
		pc_load <= rst_q & ~any_reset;
		if (any_reset) begin
			st       <= ST_RUN;
			sleeping <= 1'b0;
			sp       <= 3'h0;
			lat_cnt  <= 2'h0;
			pc_out   <= RESET_VEC;
		end else begin
			lat_cnt <= (take_irq & ~lat_done) ? lat_cnt + 2'h1 : 2'h0;
			case (st)
				ST_RUN: begin
					if (do_vec) begin
						stack[sp] <= pc_in;
						sp        <= sp + 3'h1;
						pc_load   <= 1'b1;
						pc_out    <= IRQ_VEC;
					end else if (cmd_return) begin
						sp      <= sp - 3'h1;
						pc_load <= 1'b1;
						pc_out  <= stack[sp - 3'h1];
					end else if (cmd_sleep) begin
						st       <= ST_SLEEP;
						sleeping <= 1'b1;
					end
				end
				ST_SLEEP: begin
					if (do_wake) begin
						st       <= ST_RUN;
						sleeping <= 1'b0;
						pc_load  <= 1'b1;
						if (wake_vec) begin
							stack[sp] <= pc_in + PC_ONE;
							sp        <= sp + 3'h1;
							pc_out    <= IRQ_VEC;
						end else
							pc_out <= pc_in + PC_ONE;
					end
				end
				default: begin
					st       <= ST_RUN;
					sleeping <= 1'b0;
				end
			endcase
		end
	end

	// event status, enable, clear
	wire [EVT_W-1:0] evt_set = {any_reset, do_wake, do_vec | wake_vec};
	always_ff @(posedge aclk) begin
		if (~aresetn) begin
			evt_stat <= '0;
			evt_en   <= '0;
			irq      <= 1'b0;
		end else begin
			// set wins over clear
			evt_stat <= (evt_stat & ~(wr_eclr ? wd[EVT_W-1:0] : '0)) | evt_set;
			if (wr_een)
				evt_en <= wd[EVT_W-1:0];
			irq <= |(evt_stat & evt_en);
		end
	end

	// axi write channel
	always_ff @(posedge aclk) begin
		if (~aresetn) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_ofs        <= 8'h00;
			wd            <= 32'h0;
		end else begin
			s_axi_awready <= ~aw_got & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_got & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got <= 1'b1;
				aw_ofs <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got <= 1'b1;
				wd    <= s_axi_wdata;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
		end
	end

	// axi read channel
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (s_axi_araddr[7:0])
			OFS_CTRL:     rd_mux[7:0] = ctrl;
			OFS_PFLAG1:   rd_mux[PF1_W-1:0] = pflag1;
			OFS_PFLAG2:   rd_mux[PF2_W-1:0] = pflag2;
			OFS_PEN1:     rd_mux[PF1_W-1:0] = pen1;
			OFS_PEN2:     rd_mux[PF2_W-1:0] = pen2;
			OFS_STATUS:   rd_mux[7:0] = status;
			OFS_PWR:      rd_mux[1:0] = pwr;
			OFS_PC:       rd_mux[PC_W-1:0] = pc_out;
			OFS_CMD:      rd_mux[2:0] = st;
			OFS_EVT_STAT: rd_mux[EVT_W-1:0] = evt_stat;
			OFS_EVT_EN:   rd_mux[EVT_W-1:0] = evt_en;
			OFS_EVT_CLR:  rd_mux = 32'h0;
			default:      rd_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (~aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
			ar_pend       <= 1'b0;
		end else begin
			s_axi_arready <= ~ar_pend & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				ar_pend      <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				ar_pend      <= 1'b0;
			end
		end
	end
endmodule // irq_and_reset_vectoring

/* File: irq_and_reset_vectoring_tb.sv */
`timescale 1ns/1ps
module irq_and_reset_vectoring_tb;
	import irq_vec_pkg::*;
	logic aclk = 0, aresetn = 0, master_clear_pin_n = 1, brownout_enable_cfg = 1, jump = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	localparam int NEV = 3 + PF1_W + PF2_W;
	logic [NEV-1:0] ev = 0, v;
	logic [PC_W-1:0] jump_pc = 0, jp, pc_in, pc_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pc_load, sleeping, irq;
	logic [31:0] s_axi_rdata;
	wire por_n = aresetn;
	wire ext_irq_pin, port_change_evt, timer0_ovf_evt;
	wire [PF1_W-1:0] periph_evt1;
	wire [PF2_W-1:0] periph_evt2;
	int bad_count = 0, samples_checked = 0, loads, k, g, n0, c;
	assign {periph_evt2, periph_evt1, timer0_ovf_evt, port_change_evt, ext_irq_pin} = ev;
	always #5 aclk = ~aclk;
	irq_and_reset_vectoring uut (.*);
	core_model core (.aclk(aclk), .pc_load(pc_load), .pc_out(pc_out), .jump(jump), .jump_pc(jump_pc),
		.pc_in(pc_in), .loads(loads));
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic fail_wait;
		bad_count++;
		$display("BAD %0t wait ran out", $time);
		final_report();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 50) fail_wait();
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 50) fail_wait();
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic fire(input logic [NEV-1:0] e);
		@(posedge aclk);
		ev <= e;
		@(posedge aclk);
		ev <= '0;
	endtask
	task automatic branch(input logic [PC_W-1:0] p);
		@(posedge aclk);
		jump_pc <= p;
		jump <= 1'b1;
		@(posedge aclk);
		jump <= 1'b0;
	endtask
	// counts loads seen by the core, so a load inside a bus cycle is not missed
	task automatic wait_load(input int n);
		for (c = 0; c < 40 && loads == n; c++)
			@(posedge aclk);
		if (c == 40) fail_wait();
	endtask
	function automatic logic [7:0] ctrl_flags(input logic [NEV-1:0] e);
		ctrl_flags = '0;
		ctrl_flags[B_EXT_F] = e[0];
		ctrl_flags[B_CHG_F] = e[1];
		ctrl_flags[B_TMR_F] = e[2];
	endfunction
	initial begin
		void'($urandom(94186));
		tick(5);
		aresetn <= 1'b1;
		tick(3);
		rd(OFS_STATUS);
		chk(rv[7:3], STATUS_POR[7:3]);
		rd(OFS_PWR);
		chk(rv[1:0], {1'b0, brownout_enable_cfg});
		rd(OFS_CTRL);
		chk(rv[B_GIE], 1'b0);
		chk(pc_in, RESET_VEC);
		chk(loads, 1);
		rd(8'h3c);
		chk({rr, rv}, {2'b10, 32'h0});
		wr(8'h3c, 32'h5a, 2'b10);
		$display("reset and map test done");
		for (k = 0; k < 5; k++) begin
			v = (k == 0) ? '1 : NEV'($urandom);
			// first pass: every mask but PEN2 open, global enable off
			wr(OFS_CTRL, (k == 4) ? (1 << B_GIE) : (k == 0) ? ((1 << B_EXT_E) | (1 << B_CHG_E)
				| (1 << B_TMR_E) | (1 << B_PER_E)) : 0);
			wr(OFS_PEN1, (k == 0) ? 32'hf : 0);
			wr(OFS_PFLAG1, 0);
			wr(OFS_PFLAG2, 0);
			n0 = loads;
			fire(v);
			tick(6);
			rd(OFS_CTRL);
			chk(rv[2:0], ctrl_flags(v));
			rd(OFS_PFLAG1);
			chk(rv[PF1_W-1:0], v[3 +: PF1_W]);
			rd(OFS_PFLAG2);
			chk(rv[PF2_W-1:0], v[3 + PF1_W +: PF2_W]);
			chk(loads, n0);
		end
		$display("flag test done");
		k = $urandom_range(PF1_W - 1);
		wr(OFS_PFLAG1, 0);
		wr(OFS_PEN1, 1 << k);
		wr(OFS_EVT_EN, 1 << E_VEC);
		wr(OFS_CTRL, (1 << B_GIE) | (1 << B_PER_E));
		jp = PC_W'($urandom_range(12'hfff));
		branch(jp);
		n0 = loads;
		fire(NEV'(1 << (3 + k)));
		wait_load(n0);
		chk(pc_in, IRQ_VEC);
		// two polls of slack: the core counts one edge late, the bench sees it one more
		chk((c - 2) inside {3, 4}, 1'b1);
		rd(OFS_CTRL);
		chk(rv[B_GIE], 1'b0);
		tick(2);
		chk(irq, 1'b1);
		wr(OFS_EVT_EN, 0);
		tick(2);
		chk(irq, 1'b0);
		wr(OFS_EVT_EN, 1 << E_VEC);
		tick(2);
		chk(irq, 1'b1);
		wr(OFS_EVT_CLR, 32'h7);
		tick(2);
		chk(irq, 1'b0);
		// flags cleared first, else the return re-enters at once
		// software keeps the order
		wr(OFS_PFLAG1, 0);
		n0 = loads;
		wr(OFS_CMD, 1 << C_RETURN);
		wait_load(n0);
		chk(pc_in, jp);
		rd(OFS_CTRL);
		chk(rv[B_GIE], 1'b1);
		chk(loads, n0 + 1);
		$display("vector test done");
		for (g = 0; g < 2; g++) begin
			wr(OFS_CTRL, (g << B_GIE) | (1 << B_EXT_E));
			branch(PC_W'($urandom_range(12'hfff)));
			wr(OFS_CMD, 1 << C_SLEEP);
			tick(2);
			chk(sleeping, 1'b1);
			n0 = loads;
			jp = pc_in;
			fire(NEV'(1));
			wait_load(n0);
			chk(pc_in, g ? IRQ_VEC : jp + PC_ONE);
			rd(OFS_STATUS);
			chk(rv[B_TO:B_PD], 2'b10);
			rd(OFS_CTRL);
			chk(rv[B_EXT_F], 1'b1);
		end
		$display("wake test done");
		for (g = 0; g < 2; g++) begin
			wr(OFS_PWR, 32'h3);
			// top bits set so that clearing them shows
			wr(OFS_STATUS, 32'he0 | $urandom_range(31));
			rd(OFS_STATUS);
			jp = rv[PC_W-1:0];
			if (g) wr(OFS_CMD, 1 << C_SLEEP);
			n0 = loads;
			@(posedge aclk);
			master_clear_pin_n <= 1'b0;
			tick(6);
			master_clear_pin_n <= 1'b1;
			wait_load(n0);
			tick(3);
			chk(pc_in, RESET_VEC);
			rd(OFS_STATUS);
			if (g) chk(rv[7:0], {5'b00010, jp[2:0]});
			else chk(rv[7:0], {3'b000, jp[4:0]});
			rd(OFS_PWR);
			chk(rv[1:0], 2'b11);
		end
		$display("master clear test done");
		final_report();
	end
endmodule // irq_and_reset_vectoring_tb
bind irq_and_reset_vectoring irq_vec_props chk_inst (.*);

/* File: irq_vec_pkg.sv */
package irq_vec_pkg;
	localparam int          DATA_W        = 32;
	localparam int          PC_W          = 13;
	localparam int          NSRC          = 7;
	localparam int          STK_D         = 8;
	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC   = 13'h0004;
	localparam logic [PC_W-1:0] PC_ONE    = 13'h0001;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PFLAG1   = 8'h04;
	localparam logic [7:0] OFS_PFLAG2   = 8'h08;
	localparam logic [7:0] OFS_PEN1     = 8'h0c;
	localparam logic [7:0] OFS_PEN2     = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_PWR      = 8'h18;
	localparam logic [7:0] OFS_PC       = 8'h1c;
	localparam logic [7:0] OFS_CMD      = 8'h20;
	localparam logic [7:0] OFS_EVT_STAT = 8'h24;
	localparam logic [7:0] OFS_EVT_EN   = 8'h28;
	localparam logic [7:0] OFS_EVT_CLR  = 8'h2c;
	// irq_control_reg bit positions
	localparam int B_EXT_F  = 1;
	localparam int B_CHG_F  = 0;
	localparam int B_TMR_F  = 2;
	localparam int B_EXT_E  = 4;
	localparam int B_CHG_E  = 3;
	localparam int B_TMR_E  = 5;
	localparam int B_PER_E  = 6;
	localparam int B_GIE    = 7;
	// peripheral flag widths: three control sources plus four peripheral ones make seven
	localparam int PF1_W = 3;
	localparam int PF2_W = 1;
	// status bits
	localparam int B_TO  = 4;
	localparam int B_PD  = 3;
	localparam logic [7:0] STATUS_POR = 8'h18;
	localparam logic [7:0] STATUS_TOP_MASK = 8'h1f;
	// power control bits
	localparam int B_BOR = 0;
	localparam int B_POR = 1;
	// cmd register bits
	localparam int C_RETURN = 0;
	localparam int C_SLEEP  = 1;
	localparam int C_BOR    = 2;
	localparam int C_WDT    = 3;
	// latency in clock cycles before the vector is taken
	localparam int LAT_CYC = 3;
	// event bits
	localparam int E_VEC = 0;
	localparam int E_WAKE = 1;
	localparam int E_RST = 2;
	localparam int EVT_W = 3;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAIT  = 3'b100
	} core_st_t;
endpackage

/* File: irq_vec_props.sv */
`timescale 1ns/1ps
module irq_vec_props import irq_vec_pkg::*; (
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic            master_clear_pin_n,
	input wire logic [PC_W-1:0] pc_in,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic [1:0]      s_axi_bresp,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic [1:0]      s_axi_rresp,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic            pc_load,
	input wire logic [PC_W-1:0] pc_out,
	input wire logic            sleeping
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_aw_taken_once: assert property (s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready)
		else $error("write address taken without request");
	chk_ar_taken_once: assert property (s_axi_arready |-> s_axi_arvalid ##1 !s_axi_arready)
		else $error("read address taken without request");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_err_zero_data: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("refused read carries data");
	chk_load_pulse: assert property (pc_load |=> !pc_load)
		else $error("pc load longer than one cycle");
	chk_wake_target: assert property ($fell(sleeping) && master_clear_pin_n |-> ##[0:4] pc_load &&
		(pc_out == pc_in + PC_ONE || pc_out == IRQ_VEC))
		else $error("wake did not load next pc or vector");
	chk_clear_restart: assert property ($fell(master_clear_pin_n) |-> ##[1:12] pc_load && pc_out == RESET_VEC)
		else $error("master clear did not restart at zero");
endmodule // irq_vec_props
